/* mpi_mac_pins.sv */
/*
 * MAC-side pin interface: two-entry transmit buffer drained on the PHY
 * transmit clock, receive capture on the PHY receive clock, management
 * clock divider and management data pin control.
 * Assumes both PHY clocks are far slower than the system clock and are
 * synchronous to it, so their edges are found by one sample register.
 */
`timescale 1ns/1ns

module mpi_buf2
    import mpi_pkg::*;
(
    input wire logic clk_sys_in,       // System clock.
    input wire logic reset_in,         // Synchronous reset, active high.
    input wire logic wr_valid_in,      // Writer offers a word.
    input wire mpi_word_s wr_word_in,  // Word offered.
    output logic wr_ready_out,         // Buffer can take a word.
    output logic rd_valid_out,         // Buffer holds a word.
    output mpi_word_s rd_word_out,     // Oldest word.
    input wire logic rd_ready_in       // Reader takes the oldest word.
);
    mpi_word_s mem_r [MPI_BUF_DEPTH];
    mpi_word_s mem_nxt [MPI_BUF_DEPTH];
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic do_wr, do_rd;

    assign wr_ready_out = (cnt_r != 2'h2);
    assign rd_valid_out = (cnt_r != 2'h0);
    assign rd_word_out = mem_r[rp_r];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_ready_in && rd_valid_out;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (do_wr) begin
            mem_nxt[wp_r] = wr_word_in;
            wp_nxt = ~wp_r;
        end
        if (do_rd) begin
            rp_nxt = ~rp_r;
        end
        if (do_wr && !do_rd) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (do_rd && !do_wr) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            mem_r <= mem_nxt;
        end
    end

endmodule : mpi_buf2

module mpi_mac_pins
    import mpi_pkg::*;
(
    input wire logic clk_sys_in,                 // System clock, 100 MHz.
    input wire logic reset_in,                   // Synchronous reset, active high.
    input wire logic serial_codec_mode_in,       // One-bit serial codec mode.
    input wire mpi_gp_ctrl_s gp_ctrl_in,         // Spare transmit pin levels.
    input wire logic [2:0] mgmt_clock_divider_select_in, // Management clock divider.
    input wire logic tx_valid_in,                // MAC offers a transmit word.
    input wire mpi_word_s tx_word_in,            // Transmit nibble and error flag.
    output logic tx_ready_out,                   // Buffer accepts the word.
    output logic rx_valid_out,                   // One-cycle pulse: new receive word.
    output mpi_word_s rx_word_out,               // Received nibble and error flag.
    output logic [15:0] gp_status_out,           // Sampled receive pins in codec mode.
    output logic col_out,                        // Registered collision.
    output logic crs_out,                        // Registered carrier sense.
    input wire logic mgmt_drive_in,              // MAC sends on the data pin.
    input wire logic mgmt_bit_in,                // Bit to send.
    output logic mgmt_bit_out,                   // Pin level taken at clock rise.
    output logic mdc_out,                        // Management clock pin.
    input wire logic mdio_in,                    // Management data pin, in.
    output logic mdio_out,                       // Management data pin, out.
    output logic mdio_oe_n_out,                  // Low while driving the pin.
    input wire logic tx_clk_in,                  // PHY transmit clock.
    output logic [3:0] txd_out,                  // Transmit nibble.
    output logic tx_en_out,                      // Transmit enable.
    output logic tx_er_out,                      // Transmit error.
    input wire logic col_in,                     // PHY collision.
    input wire logic crs_in,                     // PHY carrier sense.
    input wire logic rx_clk_in,                  // PHY receive clock.
    input wire logic [3:0] rxd_in,               // Receive nibble.
    input wire logic rx_dv_in,                   // Receive data valid.
    input wire logic rx_er_in                    // Receive error.
);
    logic tx_clk_q_r, rx_clk_q_r, tx_rise, rx_rise;
    logic buf_valid;
    mpi_word_s buf_word;

    // Edge finders; the PHY clocks are treated as synchronous inputs.
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            tx_clk_q_r <= 1'b0;
            rx_clk_q_r <= 1'b0;
        end else begin
            tx_clk_q_r <= tx_clk_in;
            rx_clk_q_r <= rx_clk_in;
        end
    end
    assign tx_rise = tx_clk_in && !tx_clk_q_r;
    assign rx_rise = rx_clk_in && !rx_clk_q_r;

    // The buffer drains only on transmit clock edges, so a slow PHY
    // back-pressures the MAC through tx_ready_out rather than losing words.
    mpi_buf2 u_txbuf (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .wr_valid_in(tx_valid_in),
        .wr_word_in(tx_word_in),
        .wr_ready_out(tx_ready_out),
        .rd_valid_out(buf_valid),
        .rd_word_out(buf_word),
        .rd_ready_in(tx_rise)
    );

    logic [3:0] txd_r, txd_nxt;
    logic tx_en_r, tx_en_nxt, tx_er_r, tx_er_nxt;

    always_comb begin
        txd_nxt = txd_r;
        tx_en_nxt = tx_en_r;
        tx_er_nxt = tx_er_r;
        if (tx_rise) begin
            tx_en_nxt = buf_valid;
            txd_nxt = buf_valid ? buf_word.data : MPI_TXD_RESET;
            tx_er_nxt = buf_valid && buf_word.err;
        end
        if (serial_codec_mode_in) begin
            // Spare pins follow the control bits at once, not at clock edges.
            txd_nxt[3:1] = {gp_ctrl_in.txd3, gp_ctrl_in.txd2, gp_ctrl_in.txd1};
            tx_er_nxt = gp_ctrl_in.txer;
            if (tx_rise) begin
                txd_nxt[0] = buf_valid && buf_word.data[0];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            txd_r <= MPI_TXD_RESET;
            tx_en_r <= 1'b0;
            tx_er_r <= 1'b0;
        end else begin
            txd_r <= txd_nxt;
            tx_en_r <= tx_en_nxt;
            tx_er_r <= tx_er_nxt;
        end
    end
    assign txd_out = txd_r;
    assign tx_en_out = tx_en_r;
    assign tx_er_out = tx_er_r;

    logic rx_valid_r, rx_valid_nxt, col_r, crs_r;
    mpi_word_s rx_word_r, rx_word_nxt;
    logic [15:0] status_r, status_nxt;

    always_comb begin
        rx_valid_nxt = rx_rise && rx_dv_in;
        rx_word_nxt = rx_word_r;
        status_nxt = status_r;
        if (rx_rise) begin
            rx_word_nxt.data = serial_codec_mode_in ? {3'h0, rxd_in[0]} : rxd_in;
            rx_word_nxt.err = serial_codec_mode_in ? 1'b0 : rx_er_in;
        end
        if (serial_codec_mode_in) begin
            status_nxt[MPI_ST_RXD3_BIT] = rxd_in[3];
            status_nxt[MPI_ST_RXD2_BIT] = rxd_in[2];
            status_nxt[MPI_ST_RXD1_BIT] = rxd_in[1];
            status_nxt[MPI_ST_RXER_BIT] = rx_er_in;
            status_nxt[MPI_ST_RXDV_BIT] = rx_dv_in;
        end else begin
            status_nxt = MPI_STATUS_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rx_valid_r <= 1'b0;
            rx_word_r <= '0;
            status_r <= MPI_STATUS_RESET;
            col_r <= 1'b0;
            crs_r <= 1'b0;
        end else begin
            rx_valid_r <= rx_valid_nxt;
            rx_word_r <= rx_word_nxt;
            status_r <= status_nxt;
            col_r <= col_in;
            crs_r <= crs_in;
        end
    end
    assign rx_valid_out = rx_valid_r;
    assign rx_word_out = rx_word_r;
    assign gp_status_out = status_r;
    assign col_out = col_r;
    assign crs_out = crs_r;

    logic [7:0] mdc_cnt_r, mdc_cnt_nxt, mdc_half;
    logic mdc_r, mdc_nxt, mbit_r, mbit_nxt, mdo_r, mdo_nxt, moe_n_r, moe_n_nxt;

    assign mdc_half = 8'(MPI_MDC_HALF_BASE * ({5'h0, mgmt_clock_divider_select_in} + 8'h01));

    always_comb begin
        mdc_cnt_nxt = mdc_cnt_r - 8'h01;
        mdc_nxt = mdc_r;
        mbit_nxt = mbit_r;
        if (mdc_cnt_r == 8'h00) begin
            mdc_cnt_nxt = mdc_half - 8'h01;
            mdc_nxt = ~mdc_r;
            if (!mdc_r) begin
                mbit_nxt = mdio_in;
            end
        end
        mdo_nxt = mgmt_bit_in;
        moe_n_nxt = !mgmt_drive_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mdc_cnt_r <= 8'h00;
            mdc_r <= 1'b0;
            mbit_r <= 1'b0;
            mdo_r <= 1'b0;
            moe_n_r <= 1'b1;
        end else begin
            mdc_cnt_r <= mdc_cnt_nxt;
            mdc_r <= mdc_nxt;
            mbit_r <= mbit_nxt;
            mdo_r <= mdo_nxt;
            moe_n_r <= moe_n_nxt;
        end
    end
    assign mdc_out = mdc_r;
    assign mgmt_bit_out = mbit_r;
    assign mdio_out = mdo_r;
    assign mdio_oe_n_out = moe_n_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    a_mdc_edge_count: assert property (
        (mdc_r != $past(mdc_r)) |-> ($past(mdc_cnt_r) == 8'h00))
        else $error("management clock toggled before its count ran out");
    a_mdio_drive_oe: assert property (
        mgmt_drive_in |=> (!mdio_oe_n_out && mdio_out == $past(mgmt_bit_in)))
        else $error("data pin not driven while sending");
    a_tx_en_stable: assert property (
        !tx_rise |=> $stable(tx_en_out))
        else $error("transmit enable moved between transmit clock edges");
    a_tx_en_valid: assert property (
        (tx_rise && buf_valid) |=> tx_en_out)
        else $error("transmit enable low while a word was sent");
    a_tx_idle_low: assert property (
        (tx_rise && !buf_valid && !serial_codec_mode_in) |=> (!tx_en_out && txd_out == 4'h0))
        else $error("idle transmit cycle not clean");
    a_tx_err_flag: assert property (
        (tx_rise && buf_valid && !serial_codec_mode_in) |=> (tx_er_out == $past(buf_word.err)))
        else $error("transmit error does not follow the word");
    a_codec_txd_spare: assert property (
        (serial_codec_mode_in && tx_rise && buf_valid)
        |=> (txd_out == {$past(gp_ctrl_in.txd3), $past(gp_ctrl_in.txd2),
                         $past(gp_ctrl_in.txd1), $past(buf_word.data[0])}))
        else $error("codec mode transmit pins wrong");
    a_rx_capture_word: assert property (
        (rx_rise && rx_dv_in && !serial_codec_mode_in)
        |=> (rx_valid_out && rx_word_out.data == $past(rxd_in)))
        else $error("receive nibble not captured");
    a_rx_codec_bit: assert property (
        (rx_rise && rx_dv_in && serial_codec_mode_in)
        |=> (rx_word_out.data == {3'h0, $past(rxd_in[0])}))
        else $error("codec mode receive word wrong");
    a_rx_edge_only: assert property (
        !rx_rise |=> !rx_valid_out)
        else $error("receive word without receive clock rise");
    a_gp_status_map: assert property (
        serial_codec_mode_in |=> (gp_status_out[MPI_ST_RXD2_BIT] == $past(rxd_in[2])
                                  && gp_status_out[MPI_ST_RXDV_BIT] == $past(rx_dv_in)))
        else $error("codec mode status bits wrong");

endmodule : mpi_mac_pins

/* mpi_phy_model.sv */
/*
 * Behavioural model of the external PHY facing the MAC-side pin block.
 * Assumes the bench commands it at the falling edge of the system clock.
 * Both PHY clocks stand still low outside frames.
 */
`timescale 1ns/1ns

module mpi_phy_model (
    input wire logic clk_sys_in,      // System clock.
    input wire logic reset_in,        // Synchronous reset, active high.
    input wire logic tx_run_in,       // Let the transmit clock run.
    input wire logic rx_send_in,      // Send rx_nib_in on the next clock rise.
    input wire logic [3:0] rx_nib_in, // Nibble to send.
    input wire logic rx_err_in,       // Mark the nibble as an invalid symbol.
    input wire logic col_set_in,      // Collision seen on the medium.
    input wire logic crs_set_in,      // Medium busy.
    input wire logic mdio_drive_in,   // PHY sends on the management line.
    input wire logic mdio_bit_in,     // Bit that the PHY sends.
    input wire logic mdio_oe_n_in,    // MAC drive enable, low active.
    input wire logic mdio_mac_in,     // MAC drive level.
    output logic tx_clk_out,          // Transmit clock.
    output logic rx_clk_out,          // Receive clock.
    output logic [3:0] rxd_out,       // Receive nibble.
    output logic rx_dv_out,           // Receive data valid.
    output logic rx_er_out,           // Receive error.
    output logic col_out,             // Collision.
    output logic crs_out,             // Carrier sense.
    output logic mdio_line_out        // Resolved management line level.
);
    logic div_r;

    initial begin
        div_r = 1'b0;
        tx_clk_out = 1'b0;
        rx_clk_out = 1'b0;
        rxd_out = 4'h5;
        rx_dv_out = 1'b0;
        rx_er_out = 1'b0;
    end

    // The line has a pull-up, so nobody driving reads as one.
    assign mdio_line_out = !mdio_oe_n_in ? mdio_mac_in
                           : (mdio_drive_in ? mdio_bit_in : 1'b1);
    assign col_out = col_set_in;
    assign crs_out = crs_set_in;

    always @(negedge clk_sys_in) begin
        div_r <= reset_in ? 1'b0 : ~div_r;
        if (!reset_in && div_r && (tx_run_in || tx_clk_out)) begin
            tx_clk_out <= ~tx_clk_out;
        end
        if (!reset_in && div_r && (rx_send_in || rx_clk_out)) begin
            rx_clk_out <= ~rx_clk_out;
            if (!rx_clk_out) begin
                rxd_out <= rx_nib_in;
                rx_dv_out <= 1'b1;
                rx_er_out <= rx_err_in;
            end
        end else if (!rx_send_in && !rx_clk_out) begin
            // Hold time is over: the data lines invert every cycle, so they show the last nibble only every other cycle.
            rxd_out <= ~rxd_out;
            rx_dv_out <= 1'b0;
            rx_er_out <= 1'b0;
        end
    end
endmodule : mpi_phy_model

/* mpi_pkg.sv */
/*
 * Shared constants and carrier types for the MAC-side pin interface
 * towards an external Ethernet PHY.
 * Assumes a single 100 MHz system clock; the PHY clocks arrive as
 * ordinary inputs that are synchronous to it.
 */
package mpi_pkg;

    localparam int MPI_SYS_CLK_MHZ = 100;
    localparam int MPI_BUF_DEPTH = 2;

    // Management clock half period in system cycles is
    // MPI_MDC_HALF_BASE * (select + 1).
    localparam int MPI_MDC_SEL_W = 3;
    localparam int MPI_MDC_CNT_W = 8;
    localparam logic [7:0] MPI_MDC_HALF_BASE = 8'h02;

    // Status word bit positions of the sampled receive-side pins.
    localparam int MPI_ST_RXDV_BIT = 10;
    localparam int MPI_ST_RXER_BIT = 11;
    localparam int MPI_ST_RXD3_BIT = 12;
    localparam int MPI_ST_RXD1_BIT = 13;
    localparam int MPI_ST_RXD2_BIT = 15;

    localparam logic [3:0] MPI_TXD_RESET = 4'h0;
    localparam logic [15:0] MPI_STATUS_RESET = 16'h0000;

    typedef struct packed {
        logic [3:0] data;
        logic err;
    } mpi_word_s;

    // General-purpose drive levels for the spare transmit-side pins.
    typedef struct packed {
        logic txd3;
        logic txd2;
        logic txd1;
        logic txer;
    } mpi_gp_ctrl_s;

endpackage : mpi_pkg

/* tb_top.sv */
/*
 * Self-checking bench for the MAC-side pin block with a PHY model.
 * Assumes a 100 MHz system clock and inputs driven at its falling edge.
 */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    import mpi_pkg::*;
    logic clk_sys = 0, reset = 1, codec = 0, tx_valid = 0, tx_ready, rx_valid, col_o, crs_o;
    logic mg_drive = 0, mg_bit = 0, mg_bit_o, mdc, mdio, mdio_o, mdio_oe_n, tx_clk, rx_clk;
    logic tx_en, tx_er, col, crs, rx_dv, rx_er, tx_run = 0, rx_send = 0, rx_err = 0;
    logic col_set = 0, crs_set = 0, p_drive = 0, p_bit = 0;
    logic [2:0] sel = 3'h0;
    logic [3:0] txd, rxd, rx_nib = 4'h0;
    logic [15:0] gp_status;
    mpi_gp_ctrl_s gp_ctrl = 4'h0;
    mpi_word_s tx_word = 5'h00, rx_word;
    int num_errors = 0, total_checks = 0;

    always #5 clk_sys = ~clk_sys;

    mpi_mac_pins i_mpi_mac_pins (.clk_sys_in(clk_sys), .reset_in(reset),
        .serial_codec_mode_in(codec), .gp_ctrl_in(gp_ctrl), .mgmt_clock_divider_select_in(sel),
        .tx_valid_in(tx_valid), .tx_word_in(tx_word), .tx_ready_out(tx_ready),
        .rx_valid_out(rx_valid), .rx_word_out(rx_word), .gp_status_out(gp_status),
        .col_out(col_o), .crs_out(crs_o), .mgmt_drive_in(mg_drive), .mgmt_bit_in(mg_bit),
        .mgmt_bit_out(mg_bit_o), .mdc_out(mdc), .mdio_in(mdio), .mdio_out(mdio_o),
        .mdio_oe_n_out(mdio_oe_n), .tx_clk_in(tx_clk), .txd_out(txd), .tx_en_out(tx_en),
        .tx_er_out(tx_er), .col_in(col), .crs_in(crs), .rx_clk_in(rx_clk), .rxd_in(rxd),
        .rx_dv_in(rx_dv), .rx_er_in(rx_er));

    mpi_phy_model i_mpi_phy_model (.clk_sys_in(clk_sys), .reset_in(reset), .tx_run_in(tx_run),
        .rx_send_in(rx_send), .rx_nib_in(rx_nib), .rx_err_in(rx_err), .col_set_in(col_set),
        .crs_set_in(crs_set), .mdio_drive_in(p_drive), .mdio_bit_in(p_bit),
        .mdio_oe_n_in(mdio_oe_n), .mdio_mac_in(mdio_o), .tx_clk_out(tx_clk),
        .rx_clk_out(rx_clk), .rxd_out(rxd), .rx_dv_out(rx_dv), .rx_er_out(rx_er),
        .col_out(col), .crs_out(crs), .mdio_line_out(mdio));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Reads the transmit pins at the next transmit clock fall, one and a half system cycles after they moved.
    task automatic tx_expect(input logic [3:0] d, input logic en, input logic er);
        @(negedge tx_clk);
        `CHK("txd", d, txd)
        `CHK("tx_en", en, tx_en)
        `CHK("tx_er", er, tx_er)
    endtask : tx_expect

    task automatic test_tx;
        @(negedge clk_sys);
        tx_valid <= 1'b1;
        tx_word <= {4'h3, 1'b0};
        @(negedge clk_sys);
        tx_word <= {4'hc, 1'b1};
        @(negedge clk_sys);
        tx_word <= {4'h7, 1'b0};
        repeat (3) @(negedge clk_sys);
        `CHK("tx_ready_full", 1'b0, tx_ready)
        tx_valid <= 1'b0;
        tx_run <= 1'b1;
        tx_expect(4'h3, 1'b1, 1'b0);
        tx_expect(4'hc, 1'b1, 1'b1);
        tx_expect(4'h0, 1'b0, 1'b0);
        tx_run <= 1'b0;
        codec <= 1'b1;
        gp_ctrl <= 4'ha;
        tx_valid <= 1'b1;
        tx_word <= {4'h7, 1'b1};
        @(negedge clk_sys);
        tx_valid <= 1'b0;
        repeat (6) @(negedge clk_sys);
        tx_run <= 1'b1;
        tx_expect(4'hb, 1'b1, 1'b0);
        tx_run <= 1'b0;
        codec <= 1'b0;
        $display("test transmit done");
    endtask : test_tx

    task automatic rx_expect(input logic [3:0] d, input logic e, input mpi_word_s w,
                             input logic [15:0] st);
        int n;
        @(negedge clk_sys);
        rx_send <= 1'b1;
        rx_nib <= d;
        rx_err <= e;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (rx_valid !== 1'b1 && n < 50);
        rx_send <= 1'b0;
        `CHK("rx_valid", 1'b1, rx_valid)
        `CHK("rx_word", w, rx_word)
        `CHK("gp_status", st, gp_status)
        @(negedge clk_sys);
        `CHK("rx_pulse_end", 1'b0, rx_valid)
        repeat (8) @(negedge clk_sys);
    endtask : rx_expect

    task automatic test_rx;
        rx_expect(4'h9, 1'b1, {4'h9, 1'b1}, 16'h0000);
        codec <= 1'b1;
        rx_expect(4'h5, 1'b1, {4'h1, 1'b0}, 16'h8c00);
        codec <= 1'b0;
        $display("test receive done");
    endtask : test_rx

    task automatic to_rise(output int n);
        n = 0;
        while (mdc !== 1'b0 && n < 99) begin @(negedge clk_sys); n++; end
        while (mdc !== 1'b1 && n < 99) begin @(negedge clk_sys); n++; end
    endtask : to_rise

    task automatic test_mgmt;
        int n;
        for (int s = 0; s < 3; s += 2) begin
            sel <= s[2:0];
            to_rise(n);
            to_rise(n);
            to_rise(n);
            `CHK("mdc_period", 4 * (s + 1), n)
        end
        mg_drive <= 1'b1;
        mg_bit <= 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK("mdio_oe_n", 1'b0, mdio_oe_n)
        `CHK("mdio_out", 1'b1, mdio_o)
        mg_drive <= 1'b0;
        p_drive <= 1'b1;
        to_rise(n);
        to_rise(n);
        `CHK("mdio_released", 1'b1, mdio_oe_n)
        `CHK("mgmt_bit_phy", 1'b0, mg_bit_o)
        p_drive <= 1'b0;
        to_rise(n);
        to_rise(n);
        `CHK("mgmt_bit_idle", 1'b1, mg_bit_o)
        $display("test management done");
    endtask : test_mgmt

    task automatic test_col_crs;
        for (int i = 0; i < 2; i++) begin
            col_set <= i[0] ? 1'b0 : 1'b1;
            crs_set <= i[0];
            repeat (2) @(negedge clk_sys);
            `CHK("col_out", ~i[0], col_o)
            `CHK("crs_out", i[0], crs_o)
        end
        $display("test collision and carrier done");
    endtask : test_col_crs

    initial begin
        #200000;
        num_errors++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        `CHK("reset_tx_en", 1'b0, tx_en)
        `CHK("reset_oe_n", 1'b1, mdio_oe_n)
        `CHK("reset_ready", 1'b1, tx_ready)
        test_tx();
        test_rx();
        test_mgmt();
        test_col_crs();
        report_and_stop();
    end
endmodule : tb_top
